// ---- src/pixel_unpack_pkg.sv ----
// Constants and types shared by the frame buffer pixel unpacker files.
package pixel_unpack_pkg;

   // Width of one fetched frame buffer word.
   localparam int WORD_WIDTH = 32;
   // Width of one colour, luma, chroma or alpha component.
   localparam int COMP_WIDTH = 8;
   // Width of the format select input.
   localparam int FORMAT_WIDTH = 3;
   // Width of the interleaved 4:2:2 byte order select input.
   localparam int ORDER_WIDTH = 2;
   // Width of the pixel index inside one word.
   localparam int INDEX_WIDTH = 2;

   // Byte lane numbers inside a little-endian word.
   localparam logic [1:0] LANE_0 = 2'h0;
   localparam logic [1:0] LANE_1 = 2'h1;
   localparam logic [1:0] LANE_2 = 2'h2;
   localparam logic [1:0] LANE_3 = 2'h3;

   // Bit position of the single alpha flag in the 25 bpp layout.
   localparam int ALPHA_FLAG_BIT = 24;

   // Component values used for opaque and transparent alpha.
   localparam logic [7:0] ALPHA_OPAQUE = 8'hFF;
   localparam logic [7:0] ALPHA_CLEAR = 8'h00;
   // Value driven on components other than alpha that a format does not carry.
   localparam logic [7:0] COMP_NONE = 8'h00;

   // Last pixel index for one, two and four pixels per word.
   localparam logic [1:0] LAST_INDEX_ONE = 2'h0;
   localparam logic [1:0] LAST_INDEX_TWO = 2'h1;
   localparam logic [1:0] LAST_INDEX_FOUR = 2'h3;

   // Codes of the format select input.
   localparam logic [2:0] CODE_ARGB_1888 = 3'h0;
   localparam logic [2:0] CODE_ARGB_8888 = 3'h1;
   localparam logic [2:0] CODE_RGBA_8888 = 3'h2;
   localparam logic [2:0] CODE_AYUV_444 = 3'h3;
   localparam logic [2:0] CODE_YUV_422_PACKED = 3'h4;
   localparam logic [2:0] CODE_YUV_422_SEMI = 3'h5;

   // Decoded memory layouts handled by the unpacker.
   typedef enum logic [2:0] {
      FMT_ARGB_1888,
      FMT_ARGB_8888,
      FMT_RGBA_8888,
      FMT_AYUV_444,
      FMT_YUV_422_PACKED,
      FMT_YUV_422_SEMI
   } pixel_format_type;

   // Sequencer states of the unpacker.
   typedef enum logic {
      ST_IDLE,
      ST_EMIT
   } unpack_state_type;

   // One unpacked pixel as it leaves the block.
   typedef struct packed {
      logic [7:0] alpha;
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
      logic [7:0] luma;
      logic [7:0] blueDiff;
      logic [7:0] redDiff;
      logic chromaFresh;
      logic yuv;
   } pixel_out_type;

endpackage : pixel_unpack_pkg

// ---- src/unpack_fields_if.sv ----
// Interface carrying held words and extracted fields between the unpacker modules.
`timescale 1ns/1ns
`default_nettype none
interface unpack_fields_if;
   // Layout of the held word.
   pixel_unpack_pkg::pixel_format_type format;
   // Byte order of interleaved 4:2:2 words.
   logic [1:0] byteOrder;
   // Held main word, luma plane word in semiplanar layout.
   logic [31:0] lumaWord;
   // Held chroma plane word, used in semiplanar layout only.
   logic [31:0] chromaWord;
   // Pixel index inside the held word.
   logic [1:0] pixelIndex;
   // Fields of the selected pixel.
   pixel_unpack_pkg::pixel_out_type pixel;

   // The extractor reads the words and returns the fields.
   modport extractor (input format, byteOrder, lumaWord, chromaWord, pixelIndex, output pixel);
   // The sequencer supplies the words and takes the fields.
   modport sequencer (output format, byteOrder, lumaWord, chromaWord, pixelIndex, input pixel);
endinterface : unpack_fields_if
`default_nettype wire

// ---- src/pixel_field_extract.sv ----
// Combinational extraction of one pixel's fields from a held frame buffer word.
`timescale 1ns/1ns
`default_nettype none
module pixel_field_extract (
   unpack_fields_if.extractor fields
);

   // Returns one byte lane of a word.
   function automatic logic [7:0] lane(input logic [31:0] word, input logic [1:0] idx);
      lane = word[idx * 8 +: 8];
   endfunction : lane

   // Lanes of first luma, second luma, blue-difference and red-difference.
   logic [1:0] firstLumaLane;
   logic [1:0] secondLumaLane;
   logic [1:0] blueLane;
   logic [1:0] redLane;

   // Picks the lane map of the interleaved 4:2:2 byte order.
   always_comb begin
      unique case (fields.byteOrder)
         2'h0: begin
            firstLumaLane = pixel_unpack_pkg::LANE_0;
            blueLane = pixel_unpack_pkg::LANE_1;
            secondLumaLane = pixel_unpack_pkg::LANE_2;
            redLane = pixel_unpack_pkg::LANE_3;
         end
         2'h1: begin
            blueLane = pixel_unpack_pkg::LANE_0;
            firstLumaLane = pixel_unpack_pkg::LANE_1;
            redLane = pixel_unpack_pkg::LANE_2;
            secondLumaLane = pixel_unpack_pkg::LANE_3;
         end
         2'h2: begin
            firstLumaLane = pixel_unpack_pkg::LANE_0;
            redLane = pixel_unpack_pkg::LANE_1;
            secondLumaLane = pixel_unpack_pkg::LANE_2;
            blueLane = pixel_unpack_pkg::LANE_3;
         end
         2'h3: begin
            redLane = pixel_unpack_pkg::LANE_0;
            firstLumaLane = pixel_unpack_pkg::LANE_1;
            blueLane = pixel_unpack_pkg::LANE_2;
            secondLumaLane = pixel_unpack_pkg::LANE_3;
         end
      endcase
   end

   // Slices the fields of the selected pixel out of the held words.
   always_comb begin
      fields.pixel = '0;
      fields.pixel.alpha = pixel_unpack_pkg::ALPHA_OPAQUE;
      unique case (fields.format)
         pixel_unpack_pkg::FMT_ARGB_1888: begin
            fields.pixel.blue = lane(fields.lumaWord, pixel_unpack_pkg::LANE_0);
            fields.pixel.green = lane(fields.lumaWord, pixel_unpack_pkg::LANE_1);
            fields.pixel.red = lane(fields.lumaWord, pixel_unpack_pkg::LANE_2);
            fields.pixel.alpha = fields.lumaWord[pixel_unpack_pkg::ALPHA_FLAG_BIT] ?
               pixel_unpack_pkg::ALPHA_OPAQUE : pixel_unpack_pkg::ALPHA_CLEAR;
         end
         pixel_unpack_pkg::FMT_ARGB_8888: begin
            fields.pixel.blue = lane(fields.lumaWord, pixel_unpack_pkg::LANE_0);
            fields.pixel.green = lane(fields.lumaWord, pixel_unpack_pkg::LANE_1);
            fields.pixel.red = lane(fields.lumaWord, pixel_unpack_pkg::LANE_2);
            fields.pixel.alpha = lane(fields.lumaWord, pixel_unpack_pkg::LANE_3);
         end
         pixel_unpack_pkg::FMT_RGBA_8888: begin
            fields.pixel.alpha = lane(fields.lumaWord, pixel_unpack_pkg::LANE_0);
            fields.pixel.blue = lane(fields.lumaWord, pixel_unpack_pkg::LANE_1);
            fields.pixel.green = lane(fields.lumaWord, pixel_unpack_pkg::LANE_2);
            fields.pixel.red = lane(fields.lumaWord, pixel_unpack_pkg::LANE_3);
         end
         pixel_unpack_pkg::FMT_AYUV_444: begin
            fields.pixel.yuv = 1'b1;
            fields.pixel.chromaFresh = 1'b1;
            fields.pixel.redDiff = lane(fields.lumaWord, pixel_unpack_pkg::LANE_0);
            fields.pixel.blueDiff = lane(fields.lumaWord, pixel_unpack_pkg::LANE_1);
            fields.pixel.luma = lane(fields.lumaWord, pixel_unpack_pkg::LANE_2);
            fields.pixel.alpha = lane(fields.lumaWord, pixel_unpack_pkg::LANE_3);
         end
         pixel_unpack_pkg::FMT_YUV_422_PACKED: begin
            fields.pixel.yuv = 1'b1;
            fields.pixel.luma = lane(fields.lumaWord, fields.pixelIndex[0] ? secondLumaLane : firstLumaLane);
            fields.pixel.blueDiff = lane(fields.lumaWord, blueLane);
            fields.pixel.redDiff = lane(fields.lumaWord, redLane);
            fields.pixel.chromaFresh = ~fields.pixelIndex[0];
         end
         pixel_unpack_pkg::FMT_YUV_422_SEMI: begin
            fields.pixel.yuv = 1'b1;
            fields.pixel.luma = lane(fields.lumaWord, fields.pixelIndex);
            fields.pixel.redDiff = lane(fields.chromaWord, {fields.pixelIndex[1], 1'b0});
            fields.pixel.blueDiff = lane(fields.chromaWord, {fields.pixelIndex[1], 1'b1});
            fields.pixel.chromaFresh = ~fields.pixelIndex[0];
         end
      endcase
   end

endmodule : pixel_field_extract
`default_nettype wire

// ---- src/frame_buffer_pixel_unpacker.sv ----
// Top of the frame buffer pixel unpacker: word intake, pixel sequencing and output stage.
`timescale 1ns/1ns
`default_nettype none
module frame_buffer_pixel_unpacker (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [2:0] pixelFormat,
   input wire logic [1:0] yuvByteOrder,
   input wire logic wordValid,
   output logic wordReady,
   input wire logic [31:0] wordData,
   input wire logic chromaValid,
   output logic chromaReady,
   input wire logic [31:0] chromaData,
   output logic pixelValid,
   input wire logic pixelReady,
   output logic [7:0] alpha_sample,
   output logic [7:0] redSample,
   output logic [7:0] greenSample,
   output logic [7:0] blueSample,
   output logic [7:0] luma_sample,
   output logic [7:0] blue_diff_chroma_sample,
   output logic [7:0] red_diff_chroma_sample,
   output logic chromaFresh,
   output logic yuvPixel
);

   // Link to the field extractor.
   unpack_fields_if fields ();

   // Sequencer state.
   pixel_unpack_pkg::unpack_state_type state;
   pixel_unpack_pkg::unpack_state_type next_state;
   // Layout latched with the word.
   pixel_unpack_pkg::pixel_format_type heldFormat;
   pixel_unpack_pkg::pixel_format_type next_heldFormat;
   // Byte order latched with the word.
   logic [1:0] heldOrder;
   logic [1:0] next_heldOrder;
   // Held main or luma word.
   logic [31:0] heldLuma;
   logic [31:0] next_heldLuma;
   // Held chroma plane word.
   logic [31:0] heldChroma;
   logic [31:0] next_heldChroma;
   // Index of the next pixel to emit from the held word.
   logic [1:0] pixelIndex;
   logic [1:0] next_pixelIndex;
   // Output stage holds a pixel.
   logic outValid;
   logic next_outValid;
   // Output stage pixel.
   pixel_unpack_pkg::pixel_out_type outPixel;
   pixel_unpack_pkg::pixel_out_type next_outPixel;

   // Decoded format of the input select.
   pixel_unpack_pkg::pixel_format_type inFormat;
   // The incoming word needs a chroma word beside it.
   logic inSemi;
   // A word, and its chroma word where needed, is taken this cycle.
   logic takeWord;
   // The output stage can load a pixel this cycle.
   logic stageFree;
   // Last pixel index of the held layout.
   logic [1:0] lastIndex;

   // Decodes the format select; unknown codes fall back to ARGB 8:8:8:8.
   always_comb begin
      unique case (pixelFormat)
         pixel_unpack_pkg::CODE_ARGB_1888: inFormat = pixel_unpack_pkg::FMT_ARGB_1888;
         pixel_unpack_pkg::CODE_ARGB_8888: inFormat = pixel_unpack_pkg::FMT_ARGB_8888;
         pixel_unpack_pkg::CODE_RGBA_8888: inFormat = pixel_unpack_pkg::FMT_RGBA_8888;
         pixel_unpack_pkg::CODE_AYUV_444: inFormat = pixel_unpack_pkg::FMT_AYUV_444;
         pixel_unpack_pkg::CODE_YUV_422_PACKED: inFormat = pixel_unpack_pkg::FMT_YUV_422_PACKED;
         pixel_unpack_pkg::CODE_YUV_422_SEMI: inFormat = pixel_unpack_pkg::FMT_YUV_422_SEMI;
         default: inFormat = pixel_unpack_pkg::FMT_ARGB_8888;
      endcase
   end

   // Gives the last pixel index for the layout of the held word.
   always_comb begin
      unique case (heldFormat)
         pixel_unpack_pkg::FMT_YUV_422_PACKED: lastIndex = pixel_unpack_pkg::LAST_INDEX_TWO;
         pixel_unpack_pkg::FMT_YUV_422_SEMI: lastIndex = pixel_unpack_pkg::LAST_INDEX_FOUR;
         default: lastIndex = pixel_unpack_pkg::LAST_INDEX_ONE;
      endcase
   end

   // Intake handshake: a word is taken only in idle, and a semiplanar word
   // only together with its chroma word so the two planes never slip apart.
   always_comb begin
      inSemi = (inFormat == pixel_unpack_pkg::FMT_YUV_422_SEMI);
      wordReady = (state == pixel_unpack_pkg::ST_IDLE) && (!inSemi || chromaValid);
      chromaReady = (state == pixel_unpack_pkg::ST_IDLE) && inSemi && wordValid;
      takeWord = wordReady && wordValid;
   end

   // The output stage may load when empty or when its pixel leaves now.
   assign stageFree = !outValid || pixelReady;

   // Drives the extractor with the held words.
   assign fields.format = heldFormat;
   assign fields.byteOrder = heldOrder;
   assign fields.lumaWord = heldLuma;
   assign fields.chromaWord = heldChroma;
   assign fields.pixelIndex = pixelIndex;

   // Field extractor for the pixel at the current index.
   pixel_field_extract extractor (
      .fields(fields.extractor)
   );

   // Next-state logic for the sequencer and the output stage.
   always_comb begin
      next_state = state;
      next_heldFormat = heldFormat;
      next_heldOrder = heldOrder;
      next_heldLuma = heldLuma;
      next_heldChroma = heldChroma;
      next_pixelIndex = pixelIndex;
      next_outValid = outValid;
      next_outPixel = outPixel;
      // A pixel accepted downstream empties the stage.
      if (outValid && pixelReady) begin
         next_outValid = 1'b0;
      end
      unique case (state)
         pixel_unpack_pkg::ST_IDLE: begin
            // Latches the word and its layout, then starts at pixel zero.
            if (takeWord) begin
               next_heldFormat = inFormat;
               next_heldOrder = yuvByteOrder;
               next_heldLuma = wordData;
               next_pixelIndex = '0;
               next_state = pixel_unpack_pkg::ST_EMIT;
               if (inSemi) begin
                  next_heldChroma = chromaData;
               end
            end
         end
         pixel_unpack_pkg::ST_EMIT: begin
            // Moves one pixel into the stage whenever it has room.
            if (stageFree) begin
               next_outValid = 1'b1;
               next_outPixel = fields.pixel;
               if (pixelIndex == lastIndex) begin
                  // The word is used up; the next one may be taken.
                  next_state = pixel_unpack_pkg::ST_IDLE;
               end else begin
                  next_pixelIndex = pixelIndex + 2'h1;
               end
            end
         end
      endcase
   end

   // Registers of the sequencer and the output stage.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= pixel_unpack_pkg::ST_IDLE;
         heldFormat <= pixel_unpack_pkg::FMT_ARGB_1888;
         heldOrder <= '0;
         heldLuma <= '0;
         heldChroma <= '0;
         pixelIndex <= '0;
         outValid <= 1'b0;
         outPixel <= '0;
      end else begin
         state <= next_state;
         heldFormat <= next_heldFormat;
         heldOrder <= next_heldOrder;
         heldLuma <= next_heldLuma;
         heldChroma <= next_heldChroma;
         pixelIndex <= next_pixelIndex;
         outValid <= next_outValid;
         outPixel <= next_outPixel;
      end
   end

   // Output ports come straight from the stage registers.
   assign pixelValid = outValid;
   assign alpha_sample = outPixel.alpha;
   assign redSample = outPixel.red;
   assign greenSample = outPixel.green;
   assign blueSample = outPixel.blue;
   assign luma_sample = outPixel.luma;
   assign blue_diff_chroma_sample = outPixel.blueDiff;
   assign red_diff_chroma_sample = outPixel.redDiff;
   assign chromaFresh = outPixel.chromaFresh;
   assign yuvPixel = outPixel.yuv;

endmodule : frame_buffer_pixel_unpacker
`default_nettype wire

// ---- testbench/frame_buffer_pixel_unpacker_properties.sv ----
// Concurrent checks on the ports of the frame buffer pixel unpacker.
`timescale 1ns/1ns
`default_nettype none
module frame_buffer_pixel_unpacker_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [2:0] pixelFormat,
   input wire logic wordValid,
   input wire logic wordReady,
   input wire logic chromaValid,
   input wire logic chromaReady,
   input wire logic pixelValid,
   input wire logic pixelReady,
   input wire logic [7:0] alpha_sample,
   input wire logic [7:0] redSample,
   input wire logic [7:0] greenSample,
   input wire logic [7:0] blueSample,
   input wire logic [7:0] luma_sample,
   input wire logic [7:0] blue_diff_chroma_sample,
   input wire logic [7:0] red_diff_chroma_sample,
   input wire logic chromaFresh,
   input wire logic yuvPixel
);
   // All checks sample on the rising edge and rest while reset is low.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // A word is taken when both sides agree; semiplanar also needs its chroma word.
   logic take;
   assign take = wordValid && wordReady && (pixelFormat != 3'h5 || chromaValid);

   a_valid_hold: assert property (pixelValid && !pixelReady |=> pixelValid)
      else $error("pixel withdrawn before acceptance");
   a_pixel_stable: assert property (pixelValid && !pixelReady |=> $stable({alpha_sample, redSample, greenSample,
      blueSample, luma_sample, blue_diff_chroma_sample, red_diff_chroma_sample, chromaFresh, yuvPixel}))
      else $error("pixel changed while stalled");
   a_first_latency: assert property (take && !pixelValid |=> ##1 pixelValid)
      else $error("pixel late after word taken");
   a_word_busy: assert property (take |=> !wordReady)
      else $error("word accepted while unpacking");
   a_pair_busy: assert property (take && pixelFormat == 3'h4 |=> !wordReady [*2])
      else $error("packed word released too early");
   a_quad_busy: assert property (take && pixelFormat == 3'h5 |=> !wordReady [*4])
      else $error("luma word released too early");
   a_chroma_pairs: assert property (chromaReady |-> pixelFormat == 3'h5 && wordValid)
      else $error("chroma word taken without luma word");
   a_luma_waits: assert property (pixelFormat == 3'h5 && !chromaValid |-> !wordReady)
      else $error("luma word taken without chroma word");
   a_rgb_clean: assert property (pixelValid && !yuvPixel |->
      {luma_sample, blue_diff_chroma_sample, red_diff_chroma_sample, chromaFresh} == 25'h0)
      else $error("colour pixel carries video fields");
   a_fresh_yuv: assert property (chromaFresh |-> yuvPixel)
      else $error("chroma marker on colour pixel");

   // Main scenarios reached.
   c_packed: cover property (take && pixelFormat == 3'h4);
   c_semi: cover property (take && pixelFormat == 3'h5);
   c_stall: cover property ((pixelValid && !pixelReady) [*3]);
endmodule : frame_buffer_pixel_unpacker_properties

bind frame_buffer_pixel_unpacker frame_buffer_pixel_unpacker_properties u_props (
   .clk(clk), .reset_n(reset_n), .pixelFormat(pixelFormat), .wordValid(wordValid), .wordReady(wordReady),
   .chromaValid(chromaValid), .chromaReady(chromaReady), .pixelValid(pixelValid), .pixelReady(pixelReady),
   .alpha_sample(alpha_sample), .redSample(redSample), .greenSample(greenSample), .blueSample(blueSample),
   .luma_sample(luma_sample), .blue_diff_chroma_sample(blue_diff_chroma_sample),
   .red_diff_chroma_sample(red_diff_chroma_sample), .chromaFresh(chromaFresh), .yuvPixel(yuvPixel));
`default_nettype wire

// ---- testbench/fb_fetch_model.sv ----
// Behavioural model of the bus fetch side that offers frame buffer words.
`timescale 1ns/1ns
`default_nettype none
module fb_fetch_model (
   input wire logic clk,
   input wire logic wordReady,
   input wire logic chromaReady,
   output logic wordValid,
   output logic [31:0] wordData,
   output logic chromaValid,
   output logic [31:0] chromaData
);
   // Nothing is offered at time zero.
   initial begin
      wordValid = 1'b0;
      wordData = 32'h0;
      chromaValid = 1'b0;
      chromaData = 32'h0;
   end

   // Offers one word, the chroma word lag cycles later in semiplanar mode, and holds both until taken or 40 cycles pass.
   task automatic send(input logic [31:0] w, c, input bit semi, input int lag, output bit ok);
      int n;
      ok = 1'b0;
      @(posedge clk);
      wordValid <= 1'b1;
      wordData <= w;
      for (n = 0; n < 40 && !ok; n++) begin
         if (semi && n == lag) begin
            chromaValid <= 1'b1;
            chromaData <= c;
         end
         @(negedge clk);
         ok = wordReady && (!semi || chromaReady);
         @(posedge clk);
      end
      // Released lines show the inverse so stale data is never mistaken for fresh.
      wordValid <= 1'b0;
      wordData <= ~w;
      if (semi) begin
         chromaValid <= 1'b0;
         chromaData <= ~c;
      end
   endtask : send
endmodule : fb_fetch_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the frame buffer pixel unpacker.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // Bench-driven inputs, given values at time zero.
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] pixelFormat = 3'h0;
   logic [1:0] yuvByteOrder = 2'h0;
   logic pixelReady = 1'b0;
   // Fetch model lines and block outputs.
   logic wordValid, wordReady, chromaValid, chromaReady, pixelValid, chromaFresh, yuvPixel;
   logic [31:0] wordData, chromaData;
   logic [7:0] alpha_sample, redSample, greenSample, blueSample, luma_sample;
   logic [7:0] blue_diff_chroma_sample, red_diff_chroma_sample;
   int failures = 0;
   int nTests = 0;
   pixel_unpack_pkg::pixel_out_type seenQ[$];

   // Free-running 50 ns clock.
   always #25 clk = ~clk;

   frame_buffer_pixel_unpacker DUT (.clk(clk), .reset_n(reset_n), .pixelFormat(pixelFormat),
      .yuvByteOrder(yuvByteOrder), .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData),
      .chromaValid(chromaValid), .chromaReady(chromaReady), .chromaData(chromaData), .pixelValid(pixelValid),
      .pixelReady(pixelReady), .alpha_sample(alpha_sample), .redSample(redSample), .greenSample(greenSample),
      .blueSample(blueSample), .luma_sample(luma_sample), .blue_diff_chroma_sample(blue_diff_chroma_sample),
      .red_diff_chroma_sample(red_diff_chroma_sample), .chromaFresh(chromaFresh), .yuvPixel(yuvPixel));

   fb_fetch_model FB (.clk(clk), .wordReady(wordReady), .chromaReady(chromaReady), .wordValid(wordValid),
      .wordData(wordData), .chromaValid(chromaValid), .chromaData(chromaData));

   // Every accepted pixel is queued for the scenarios to judge.
   always @(posedge clk) begin
      if (reset_n && pixelValid === 1'b1 && pixelReady === 1'b1) begin
         seenQ.push_back({alpha_sample, redSample, greenSample, blueSample, luma_sample,
            blue_diff_chroma_sample, red_diff_chroma_sample, chromaFresh, yuvPixel});
      end
   end

   // Expected colour and video pixels.
   function automatic pixel_unpack_pkg::pixel_out_type rgb(input logic [7:0] a, input logic [23:0] c);
      return {a, c, 24'h0, 2'b00};
   endfunction : rgb
   function automatic pixel_unpack_pkg::pixel_out_type yuv(input logic [7:0] a, y, cb, cr, input logic f);
      return {a, 24'h0, y, cb, cr, f, 1'b1};
   endfunction : yuv
   function automatic pixel_unpack_pkg::pixel_out_type pq();
      return seenQ.pop_front();
   endfunction : pq

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input pixel_unpack_pkg::pixel_out_type seen, exp, input string what);
      nTests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic set_mode(input logic [2:0] f, input logic [1:0] o);
      @(posedge clk);
      pixelFormat <= f;
      yuvByteOrder <= o;
   endtask : set_mode

   // Hands one word to the fetch model; a word never taken ends the run.
   task automatic word(input logic [31:0] w, c, input bit semi, input int lag);
      bit ok;
      FB.send(w, c, semi, lag, ok);
      if (!ok) begin
         failures++;
         $display("[FAIL] %0t word never taken", $time);
         end_of_test();
      end
   endtask : word

   // Bounded wait for n queued pixels.
   task automatic wait_px(input int n);
      int k;
      for (k = 0; k < 60 && seenQ.size() < n; k++) begin
         @(negedge clk);
      end
      if (seenQ.size() < n) begin
         failures++;
         $display("[FAIL] %0t pixels missing", $time);
         end_of_test();
      end
   endtask : wait_px

   // Colour formats, back to back, with top bits set in the flag-clear 25 bpp word.
   task automatic test_rgb();
      set_mode(3'h0, 2'h0);
      word(32'hFEABCDEF, 32'h0, 1'b0, 0);
      word(32'h01123456, 32'h0, 1'b0, 0);
      wait_px(2);
      check(pq(), rgb(8'h00, 24'hABCDEF), "flag clear");
      check(pq(), rgb(8'hFF, 24'h123456), "flag set");
      set_mode(3'h1, 2'h0);
      word(32'h8899AABB, 32'h0, 1'b0, 0);
      set_mode(3'h2, 2'h0);
      word(32'h8899AABB, 32'h0, 1'b0, 0);
      wait_px(2);
      check(pq(), rgb(8'h88, 24'h99AABB), "alpha first");
      check(pq(), rgb(8'hBB, 24'h8899AA), "alpha last");
      // An unused format code must fall back to the alpha-first layout.
      set_mode(3'h7, 2'h0);
      word(32'h8899AABB, 32'h0, 1'b0, 0);
      wait_px(1);
      check(pq(), rgb(8'h88, 24'h99AABB), "fallback code");
      $display("test_rgb done");
   endtask : test_rgb

   task automatic test_yuv444();
      set_mode(3'h3, 2'h0);
      word(32'h8899AABB, 32'h0, 1'b0, 0);
      wait_px(1);
      check(pq(), yuv(8'h88, 8'h99, 8'hAA, 8'hBB, 1'b1), "full chroma");
      $display("test_yuv444 done");
   endtask : test_yuv444

   // All four byte orders, each with the output stalled for three cycles.
   task automatic test_packed();
      logic [7:0] y0, y1, cb, cr;
      int o;
      for (o = 0; o < 4; o++) begin
         set_mode(3'h4, o[1:0]);
         pixelReady <= 1'b0;
         word(32'h44332211, 32'h0, 1'b0, 0);
         repeat (4) @(posedge clk);
         pixelReady <= 1'b1;
         wait_px(2);
         case (o)
            0: {cr, y1, cb, y0} = 32'h44332211;
            1: {y1, cr, y0, cb} = 32'h44332211;
            2: {cb, y1, cr, y0} = 32'h44332211;
            default: {y1, cb, y0, cr} = 32'h44332211;
         endcase
         check(pq(), yuv(8'hFF, y0, cb, cr, 1'b1), "first luma");
         check(pq(), yuv(8'hFF, y1, cb, cr, 1'b0), "second luma");
      end
      $display("test_packed done");
   endtask : test_packed

   // Two plane pairs, the first with chroma arriving three cycles late.
   task automatic test_semi();
      logic [31:0] lw [2];
      logic [31:0] cw [2];
      int k;
      int p;
      lw = '{32'h44332211, 32'hDDCCBBAA};
      cw = '{32'h88776655, 32'h13579BDF};
      set_mode(3'h5, 2'h0);
      word(lw[0], cw[0], 1'b1, 3);
      word(lw[1], cw[1], 1'b1, 0);
      wait_px(8);
      for (k = 0; k < 2; k++) begin
         for (p = 0; p < 4; p++) begin
            check(pq(), yuv(8'hFF, lw[k][8*p+:8], cw[k][16*(p/2)+8+:8], cw[k][16*(p/2)+:8], (p % 2) == 0),
               "semiplanar");
         end
      end
      $display("test_semi done");
   endtask : test_semi

   // Reset for three cycles, then the scenarios and the verdict.
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      pixelReady <= 1'b1;
      test_rgb();
      test_yuv444();
      test_packed();
      test_semi();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
